/* File: common/cmc_pkg.sv */
// Purpose: Constants and types for the current-mode PWM conditioning block.
// Assumes: Peripheral timing is quoted at 4 MHz and derived from hclk.
// Notes: Window periods are held in peripheral ticks.
`default_nettype none
package cmc_pkg;
    // Register byte offsets.
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] FILT_OFF = 8'h04;
    localparam logic [7:0] AMP_OFF = 8'h08;
    localparam logic [7:0] TIM_OFF = 8'h0c;
    localparam logic [7:0] STAT_OFF = 8'h10;
    // Field positions.
    localparam int BLANK_LSB = 0;
    localparam int COUNT_LSB = 4;
    localparam int FREQ_LSB = 0;
    localparam int OFFT_LSB = 4;
    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] BLANK_RST = 3'h0;
    localparam logic [2:0] COUNT_RST = 3'h0;
    localparam logic [1:0] AMP_RST = 2'h0;
    localparam logic [3:0] FREQ_RST = 4'h0;
    localparam logic [3:0] OFFT_RST = 4'h0;
    // Timing.
    localparam int CLK_MHZ = 100;
    localparam int PERIPH_MHZ = 4;
    localparam int PERIPH_DIV = CLK_MHZ / PERIPH_MHZ;
    localparam int SAMPLE_DIV = 4;
    localparam int BLANK_STEP_NS = 500;
    localparam int BLANK_STEP_TICKS = BLANK_STEP_NS * PERIPH_MHZ / 1000;
    localparam int OFF_STEP_NS = 2500;
    localparam int OFF_STEP_TICKS = OFF_STEP_NS * PERIPH_MHZ / 1000;

    typedef struct packed {
        logic [3:0] sampling_delay_sel;
        logic on_time_sampling;
        logic sensor_mode_flag;
        logic direct_access;
        logic clk_enable;
    } cmc_ctrl_type;

    typedef struct packed {
        logic comparator_input_select;
        logic amplifier_on;
    } cmc_amp_type;

    // Window period in peripheral ticks for each frequency code.
    function automatic logic [13:0] window_period(input logic [3:0] code);
        case (code)
            4'h0: window_period = 14'd80;
            4'h1: window_period = 14'd100;
            4'h2: window_period = 14'd120;
            4'h3: window_period = 14'd160;
            4'h4: window_period = 14'd200;
            4'h5: window_period = 14'd221;
            4'h6: window_period = 14'd260;
            4'h7: window_period = 14'd320;
            4'h8: window_period = 14'd400;
            4'h9: window_period = 14'd640;
            4'ha: window_period = 14'd1278;
            4'hb: window_period = 14'd2564;
            4'hc: window_period = 14'd3200;
            4'hd: window_period = 14'd4162;
            4'he: window_period = 14'd6400;
            default: window_period = 14'd10256;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: rtl/cmc_pwm_cond.sv */
// Purpose: Blanking, consecutive-sample filter and measurement window for current-mode PWM.
// Assumes: One hclk domain; the comparator output arrives asynchronously from a pin.
// Notes: The peripheral clock is a tick derived from hclk by a divider.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cmc_pwm_cond #(
    parameter int PERIPH_DIV = cmc_pkg::PERIPH_DIV
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Analog front end.
    input wire logic comparator_in,
    output cmc_pkg::cmc_amp_type amp_ctrl,
    output logic comparator_enable,
    // PWM and window outputs.
    output logic pwm_out,
    output logic window_out,
    output logic current_limit_event
);
    // The divider counter is sixteen bits wide, which bounds the ratio from above.
    if (PERIPH_DIV < 1 || PERIPH_DIV > 65536) begin : g_bad_div
        $error("PERIPH_DIV must lie between 1 and 65536");
    end

    cmc_pkg::cmc_ctrl_type ctrl;
    logic [2:0] blanking_length_sel;
    logic [2:0] feedback_sample_count;
    logic [3:0] window_freq_select;
    logic [3:0] min_off_time_sel;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rd_mux;
    logic cmp_meta;
    logic cmp_sync;
    logic [15:0] div_cnt;
    logic tick;
    logic active;
    logic [1:0] sph;
    logic sample;
    logic [13:0] wcnt;
    logic [13:0] next_wcnt;
    logic [13:0] period;
    logic [13:0] off_ticks;
    logic full;
    logic on_start;
    logic on_end;
    logic pwm_on;
    logic next_pwm_on;
    logic [4:0] bcnt;
    logic [3:0] cnt;
    logic judge;
    logic limit_now;

    // Minimum off time in ticks; zero when sampling happens during ON time.
    function automatic logic [13:0] min_off(input cmc_pkg::cmc_ctrl_type c, input logic [3:0] sel);
        if (c.sensor_mode_flag || c.on_time_sampling || c.sampling_delay_sel != 4'h0)
        begin
            min_off = 14'h0000;
        end
        else
        begin
            min_off = 14'((sel + 5'h01) * cmc_pkg::OFF_STEP_TICKS);
        end
    endfunction

    // Zero-wait slave: reads are decoded in the address phase.
    always_comb
    begin
        case (haddr[7:0])
            cmc_pkg::CTRL_OFF: rd_mux = {24'h000000, ctrl};
            cmc_pkg::FILT_OFF: rd_mux = {25'h0000000, feedback_sample_count, 1'b0, blanking_length_sel};
            cmc_pkg::AMP_OFF: rd_mux = {30'h00000000, amp_ctrl};
            cmc_pkg::TIM_OFF: rd_mux = {24'h000000, min_off_time_sel, window_freq_select};
            cmc_pkg::STAT_OFF: rd_mux = {24'h000000, active, cnt[2:0], cmp_sync, window_out, bcnt != 5'h00, pwm_on};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready)
            begin
                wr_addr <= haddr[7:0];
                if (!hwrite)
                begin
                    hrdata <= rd_mux;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= cmc_pkg::CTRL_RST;
            blanking_length_sel <= cmc_pkg::BLANK_RST;
            feedback_sample_count <= cmc_pkg::COUNT_RST;
            amp_ctrl <= cmc_pkg::AMP_RST;
            window_freq_select <= cmc_pkg::FREQ_RST;
            min_off_time_sel <= cmc_pkg::OFFT_RST;
        end
        else if (wr_pend)
        begin
            case (wr_addr)
                cmc_pkg::CTRL_OFF: ctrl <= hwdata[7:0];
                cmc_pkg::FILT_OFF:
                begin
                    blanking_length_sel <= hwdata[cmc_pkg::BLANK_LSB +: 3];
                    feedback_sample_count <= hwdata[cmc_pkg::COUNT_LSB +: 3];
                end
                cmc_pkg::AMP_OFF: amp_ctrl <= hwdata[1:0];
                cmc_pkg::TIM_OFF:
                begin
                    window_freq_select <= hwdata[cmc_pkg::FREQ_LSB +: 4];
                    min_off_time_sel <= hwdata[cmc_pkg::OFFT_LSB +: 4];
                end
                default:
                begin
                end
            endcase
        end
    end

    // The first stage feeds only the second.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end
        else
        begin
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
        end
    end

    assign active = ctrl.clk_enable || ctrl.direct_access;
    assign tick = active && div_cnt == 16'(PERIPH_DIV - 1);
    assign sample = tick && sph == 2'(cmc_pkg::SAMPLE_DIV - 1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt <= 16'h0000;
            sph <= 2'h0;
        end
        else if (!active)
        begin
            div_cnt <= 16'h0000;
            sph <= 2'h0;
        end
        else
        begin
            div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
            sph <= tick ? sph + 2'h1 : sph;
        end
    end

    // Window generator: window is high for the first off_ticks of each period, and stays low when off_ticks reaches the period.
    assign period = cmc_pkg::window_period(window_freq_select);
    assign off_ticks = min_off(ctrl, min_off_time_sel);
    assign full = off_ticks >= period;
    assign next_wcnt = (wcnt >= period - 14'h0001) ? 14'h0000 : wcnt + 14'h0001;
    assign on_start = tick && !full && next_wcnt == off_ticks;
    assign on_end = tick && next_wcnt == 14'h0000 && off_ticks != 14'h0000;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wcnt <= 14'h0000;
        end
        else if (!active)
        begin
            wcnt <= 14'h0000;
        end
        else if (tick)
        begin
            wcnt <= next_wcnt;
        end
    end

    // Blanking counts down in peripheral ticks after every turn-on at on_start; the turn-on when off_ticks fills the period loads none.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bcnt <= 5'h00;
        end
        else if (on_start)
        begin
            bcnt <= 5'(blanking_length_sel * cmc_pkg::BLANK_STEP_TICKS);
        end
        else if (tick && bcnt != 5'h00)
        begin
            bcnt <= bcnt - 5'h01;
        end
    end

    // A sample only counts while ON and outside the blanking interval.
    // A sample in the turn-on cycle belongs to the phase that is ending, so it is dropped.
    assign judge = sample && pwm_on && !full && !on_start && bcnt == 5'h00;
    assign limit_now = judge && cmp_sync && cnt == {1'b0, feedback_sample_count};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= 4'h0;
        end
        else if (!active || on_start || limit_now)
        begin
            cnt <= 4'h0;
        end
        else if (judge)
        begin
            cnt <= cmp_sync ? cnt + 4'h1 : 4'h0;
        end
    end

    always_comb
    begin
        if (!active)
        begin
            next_pwm_on = 1'b0;
        end
        else if (full || on_start)
        begin
            next_pwm_on = 1'b1;
        end
        else if (on_end || limit_now)
        begin
            next_pwm_on = 1'b0;
        end
        else
        begin
            next_pwm_on = pwm_on;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pwm_on <= 1'b0;
            pwm_out <= 1'b0;
            window_out <= 1'b0;
            current_limit_event <= 1'b0;
            comparator_enable <= 1'b0;
        end
        else
        begin
            pwm_on <= next_pwm_on;
            pwm_out <= next_pwm_on;
            // Between ticks the window follows the held count, so it stays aligned with the PWM edge.
            window_out <= active && !full && (tick ? next_wcnt : wcnt) < off_ticks;
            current_limit_event <= limit_now;
            comparator_enable <= active;
        end
    end

    // Turn-on loads the full blanking length.
    blank_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pwm_on) && !$past(full) |-> bcnt == 5'($past(blanking_length_sel) * cmc_pkg::BLANK_STEP_TICKS))
        else $error("blanking length wrong at turn-on");

    blank_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
        current_limit_event |-> $past(bcnt) == 5'h00 && $past(pwm_on))
        else $error("limit event during blanking or while off");

    blank_reset_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> blanking_length_sel == 3'h0)
        else $error("blanking length not zero after reset");

    limit_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        current_limit_event |-> $past(cmp_sync) && $past(cnt) == {1'b0, $past(feedback_sample_count)})
        else $error("limit event without enough samples");

    sample_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sample |=> !sample [*3])
        else $error("comparator sampled too often");

    limit_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        current_limit_event |-> !pwm_on)
        else $error("PWM still on after limit event");

    comp_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !active |=> !pwm_on && !current_limit_event && !comparator_enable)
        else $error("comparator path active while disabled");

    full_duty_a: assert property (@(posedge hclk) disable iff (!hresetn)
        active && full |=> pwm_out)
        else $error("no constant high with long off time");

    count_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        on_start |=> cnt == 4'h0)
        else $error("sample counter not cleared at turn-on");
endmodule // cmc_pwm_cond
`default_nettype wire

/* File: testbench/cmc_pwm_cond_bench.sv */
// Purpose: Self-checking bench for the current-mode PWM conditioning block.
// Assumes: PERIPH_DIV is 1, so one peripheral tick is one hclk cycle.
// Notes: Outputs are observed at the falling edge, inputs change after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module cmc_pwm_cond_bench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic comparator_in = 1'b0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    cmc_pkg::cmc_amp_type amp_ctrl;
    logic comparator_enable;
    logic pwm_out;
    logic window_out;
    logic current_limit_event;
    int fail_count = 0;
    int check_count = 0;
    logic [31:0] q;

    cmc_pwm_cond #(.PERIPH_DIV(1)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comparator_in(comparator_in),
        .amp_ctrl(amp_ctrl), .comparator_enable(comparator_enable), .pwm_out(pwm_out),
        .window_out(window_out), .current_limit_event(current_limit_event));

    initial forever #5 hclk = ~hclk;

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One idle cycle precedes every transfer, so a read-back never overlaps the write.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge hclk iff hreadyout === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        q = hrdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge hclk);
    endtask

    task automatic wait_win(input logic lvl);
        do @(negedge hclk); while (window_out !== lvl);
    endtask

    task automatic t_regs();
        logic [7:0] offs [5];
        offs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
        `CHK("cmp_en idle", 0, comparator_enable);
        bus(1'b1, 8'h14, 32'hffffffff);
        foreach (offs[i])
        begin
            bus(1'b0, offs[i], 0);
            `CHK("reset value", 0, q);
        end
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, cmc_pkg::AMP_OFF, i);
            bus(1'b0, cmc_pkg::AMP_OFF, 0);
            `CHK("amp reg", i, q);
            `CHK("amp_ctrl", i, amp_ctrl);
        end
        `CHK("amp both set", 3, amp_ctrl);
        bus(1'b1, cmc_pkg::FILT_OFF, 32'h77);
        bus(1'b0, cmc_pkg::FILT_OFF, 0);
        `CHK("filter reg", 32'h77, q);
        bus(1'b1, cmc_pkg::FILT_OFF, 0);
    endtask

    // The comparator is held high before enabling: nothing may react yet.
    task automatic t_enable();
        @(posedge hclk);
        comparator_in <= 1'b1;
        cyc(60);
        `CHK("pwm before enable", 0, pwm_out);
        @(posedge hclk);
        comparator_in <= 1'b0;
        bus(1'b1, cmc_pkg::CTRL_OFF, 1);
        cyc(3);
        `CHK("cmp_en", 1, comparator_enable);
        bus(1'b0, cmc_pkg::STAT_OFF, 0);
        `CHK("status active", 1, q[7]);
    endtask

    task automatic t_window(input logic [3:0] f, input logic [3:0] o, input int per);
        int w;
        int p;
        bus(1'b1, cmc_pkg::TIM_OFF, {o, f});
        wait_win(1);
        wait_win(0);
        wait_win(1);
        `CHK("pwm in window", 0, pwm_out);
        w = 0;
        while (window_out === 1'b1)
        begin
            w++;
            cyc(1);
        end
        p = w;
        cyc(1);
        `CHK("pwm after window", 1, pwm_out);
        while (window_out !== 1'b1)
        begin
            p++;
            cyc(1);
        end
        `CHK("window width", (o + 1) * cmc_pkg::OFF_STEP_TICKS, w);
        `CHK("window period", per, p + 1);
    endtask

    task automatic t_limit(input int b, input int c);
        int t;
        int lo;
        int hi;
        lo = b * cmc_pkg::BLANK_STEP_TICKS + c * cmc_pkg::SAMPLE_DIV + 1;
        hi = lo + cmc_pkg::SAMPLE_DIV + 6;
        bus(1'b1, cmc_pkg::FILT_OFF, c * 16 + b);
        wait_win(1);
        @(posedge hclk);
        comparator_in <= 1'b1;
        wait_win(0);
        t = 0;
        do
        begin
            cyc(1);
            t++;
        end
        while (current_limit_event !== 1'b1 && t < 200);
        `CHK("limit not early", 1, t >= lo);
        `CHK("limit not late", 1, t <= hi);
        t = 0;
        while (window_out !== 1'b1)
        begin
            cyc(1);
            t += (pwm_out !== 1'b0);
        end
        `CHK("pwm off after limit", 0, t);
        @(posedge hclk);
        comparator_in <= 1'b0;
    endtask

    // A low sample every 16 cycles must keep a run of four high samples from ever completing.
    task automatic t_restart();
        int ev;
        ev = 0;
        bus(1'b1, cmc_pkg::FILT_OFF, 32'h30);
        wait_win(1);
        wait_win(0);
        for (int i = 0; i < 64; i++)
        begin
            @(posedge hclk);
            comparator_in <= (i % 16 < 12);
            @(negedge hclk);
            ev += current_limit_event;
        end
        `CHK("limit events", 0, ev);
        @(posedge hclk);
        comparator_in <= 1'b0;
    endtask

    task automatic t_idle(input logic [7:0] ctrl, input logic [7:0] tim, input logic cmp);
        int wn;
        int lo;
        bus(1'b1, cmc_pkg::TIM_OFF, tim);
        bus(1'b1, cmc_pkg::CTRL_OFF, ctrl);
        comparator_in <= cmp;
        cyc(200);
        wn = 0;
        lo = 0;
        repeat (300)
        begin
            cyc(1);
            wn += (window_out !== 1'b0) && (tim == 0);
            lo += (pwm_out !== 1'b1);
        end
        `CHK("window width zero", 0, wn);
        `CHK("pwm never low", 0, lo);
        @(posedge hclk);
        comparator_in <= 1'b0;
    endtask

    initial
    begin
        #300us;
        fail_count++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_enable();
        t_window(4'h0, 4'h0, 80);
        t_window(4'h1, 4'h3, 100);
        t_window(4'h5, 4'h1, 221);
        bus(1'b1, cmc_pkg::TIM_OFF, 0);
        t_limit(0, 0);
        t_limit(0, 7);
        t_limit(3, 2);
        t_limit(7, 0);
        t_restart();
        t_idle(8'h05, 8'h00, 1'b0);
        t_idle(8'h09, 8'h00, 1'b0);
        t_idle(8'h11, 8'h00, 1'b0);
        t_idle(8'h01, 8'hf0, 1'b1);
        close_out();
    end
endmodule // cmc_pwm_cond_bench
`default_nettype wire
